// ---- design/mch_mode_upper.sv ----
// upper mode code handler: response, storage and error logic for codes 10011..11111
// Contract
// (R1) tx BIT word: status then one BIT word
// (R2) internal BIT register unless both enables set
// (R3) both enables set: BIT word from RAM
// (R4) no enhanced codes: use SA0/31 pointer
// (R5) enhanced codes: external BIT word at 0123
// (R6) invalid command: ignore, no reply
// (R7) tx BIT plus data: error, high count
// (R8) rx 10011 no data: error, low count
// (R9) rx 10011 one word: status, store 0113
// (R10) bcst rx 10011 word: store 0133, no status
// (R11) bcst tx BIT: error, bcst, command error
// (R12) shutdown rx: store 0114, send status
// (R13) shutdown disables no transmitter, nothing else
// (R14) override rx: store 0115, reactivate nothing
// (R15) broadcast receive: set bcst, no status
// (R16) receive missing word: error, low count
// (R17) receive extra words: error, high count
// (R18) tx 10100/10101 with data: error, high
// (R19) tx 10100/10101: status plus 0124/0125 word
// (R20) bcst tx 10100/10101: error, bcst, command
// (R21) reserved codes: store rx, reply tx
// (R22) enhanced reserved map 0116/0126/0136 ranges
`timescale 1ns/1ps
`default_nettype none
module mch_mode_upper (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // decoded message from the bus side
  input wire logic msg_valid,
  input wire mch_pkg::mch_msg_s msg,
  output logic busy,
  // response to the encoder
  output logic resp_valid,
  output mch_pkg::mch_resp_s resp,
  // shared ram port
  output logic ram_valid,
  output mch_pkg::mch_ram_s ram,
  input wire logic ram_ack,
  input wire logic [15:0] ram_rdata,
  // status word and bit word flags
  output logic msg_err,
  output logic bcst_rx,
  output logic [15:0] bit_word
);
  import mch_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] cfg3;
  logic [15:0] cfg4;
  logic [15:0] ptr_rx0;
  logic [15:0] ptr_rx31;
  logic [15:0] ptr_tx0;
  logic [15:0] ptr_tx31;
  mch_state_e state;
  logic pend_status;

  // ****************************************
  // bus decode
  // ****************************************
  wire bus_req = (avs_read || avs_write) && avs_waitrequest;
  wire wr_go = avs_write && !avs_waitrequest;
  wire wr_cfg3 = wr_go && (avs_address == OFS_CFG3);
  wire wr_cfg4 = wr_go && (avs_address == OFS_CFG4);
  wire wr_prx0 = wr_go && (avs_address == OFS_PTR_RX0);
  wire wr_prx31 = wr_go && (avs_address == OFS_PTR_RX31);
  wire wr_ptx0 = wr_go && (avs_address == OFS_PTR_TX0);
  wire wr_ptx31 = wr_go && (avs_address == OFS_PTR_TX31);
  wire wr_bitw = wr_go && (avs_address == OFS_BITW);
  wire wr_stat = wr_go && (avs_address == OFS_STAT);
  wire [15:0] clr_bits = merge16(16'h0000, avs_writedata, avs_byteenable);
  wire [15:0] stat_word = {14'h0000, msg_err, bcst_rx};
  wire [15:0] rd_word =
    (avs_address == OFS_CFG3) ? cfg3 :
    (avs_address == OFS_CFG4) ? cfg4 :
    (avs_address == OFS_PTR_RX0) ? ptr_rx0 :
    (avs_address == OFS_PTR_RX31) ? ptr_rx31 :
    (avs_address == OFS_PTR_TX0) ? ptr_tx0 :
    (avs_address == OFS_PTR_TX31) ? ptr_tx31 :
    (avs_address == OFS_BITW) ? bit_word :
    (avs_address == OFS_STAT) ? stat_word : 16'h0000;

  // ****************************************
  // message decode
  // ****************************************
  wire enh_mc = cfg3[CFG3_ENH_MODE] && cfg3[CFG3_ENH_MC];
  wire ext_bit = cfg3[CFG3_ENH_MODE] && cfg4[CFG4_EXT_BIT]; // (R2) (R3)
  wire take = msg_valid && (state == ST_IDLE);
  wire mine = take && msg.ok && (msg.code >= MC_FIRST); // (R6)
  wire is_bit = (msg.code == MC_TX_BIT);
  wire no_data = (msg.ndata == 2'b00);
  wire one_data = (msg.ndata == 2'b01);
  // transmit branch
  wire tx_bcst = msg.tx && msg.bcst; // (R11) (R20)
  wire tx_data = msg.tx && !msg.bcst && !no_data; // (R7) (R18)
  wire tx_ok = msg.tx && !msg.bcst && no_data; // (R1) (R19) (R21)
  // receive branch
  wire rx_lo = !msg.tx && no_data; // (R8) (R16)
  wire rx_hi = !msg.tx && !no_data && !one_data; // (R17)
  wire rx_ok = !msg.tx && one_data; // (R9) (R12) (R14) (R21)
  // error flag terms
  wire set_me = mine && (tx_bcst || tx_data || rx_lo || rx_hi);
  wire set_bcr = mine && msg.bcst; // (R15)
  wire set_hi = mine && (tx_data || rx_hi);
  wire set_lo = mine && rx_lo;
  wire set_cc = mine && tx_bcst;
  // ram use: internal BIT word needs no ram cycle
  wire tx_int = tx_ok && is_bit && !ext_bit; // (R2)
  wire go_rd = mine && tx_ok && !tx_int; // (R3)
  wire go_wr = mine && rx_ok;
  // enhanced map: page 01, nibble by broadcast or else by direction, low nibble of code
  wire [3:0] enh_nib = msg.bcst ? ENH_BC_NIB : (msg.tx ? ENH_TX_NIB : ENH_RX_NIB);
  wire [15:0] enh_addr = {ENH_PAGE, enh_nib, msg.code[3:0]}; // (R5) (R9) (R10) (R22)
  wire [15:0] ptr_rx = msg.sa31 ? ptr_rx31 : ptr_rx0;
  wire [15:0] ptr_tx = msg.sa31 ? ptr_tx31 : ptr_tx0;
  wire [15:0] lut_addr = msg.tx ? ptr_tx : ptr_rx; // (R4) (R21)
  wire [15:0] ram_addr_sel = enh_mc ? enh_addr : lut_addr;

  // ****************************************
  // next values
  // ****************************************
  wire [15:0] bit_set = ({15'h0000, set_hi} << BIT_HI_WC) | ({15'h0000, set_lo} << BIT_LO_WC)
    | ({15'h0000, set_cc} << BIT_CMD_ERR);
  wire [15:0] bit_clr = wr_bitw ? clr_bits : 16'h0000;
  // a flag raised in the clearing cycle survives
  wire [15:0] next_bit_word = (bit_word & ~bit_clr) | bit_set;
  wire next_msg_err = (msg_err && !(wr_stat && clr_bits[ST_MSG_ERR])) || set_me;
  wire next_bcst_rx = (bcst_rx && !(wr_stat && clr_bits[ST_BCST_RX])) || set_bcr;

  // ****************************************
  // avalon slave: one wait cycle, then answer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        avs_readdata <= {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg3 <= RST_WORD;
      cfg4 <= RST_WORD;
      ptr_rx0 <= RST_WORD;
      ptr_rx31 <= RST_WORD;
      ptr_tx0 <= RST_WORD;
      ptr_tx31 <= RST_WORD;
    end else begin
      if (wr_cfg3) begin
        cfg3 <= merge16(cfg3, avs_writedata, avs_byteenable);
      end
      if (wr_cfg4) begin
        cfg4 <= merge16(cfg4, avs_writedata, avs_byteenable);
      end
      if (wr_prx0) begin
        ptr_rx0 <= merge16(ptr_rx0, avs_writedata, avs_byteenable);
      end
      if (wr_prx31) begin
        ptr_rx31 <= merge16(ptr_rx31, avs_writedata, avs_byteenable);
      end
      if (wr_ptx0) begin
        ptr_tx0 <= merge16(ptr_tx0, avs_writedata, avs_byteenable);
      end
      if (wr_ptx31) begin
        ptr_tx31 <= merge16(ptr_tx31, avs_writedata, avs_byteenable);
      end
    end
  end

  // ****************************************
  // status and bit word flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_word <= RST_WORD;
      msg_err <= 1'b0;
      bcst_rx <= 1'b0;
    end else begin
      bit_word <= next_bit_word; // (R7) (R8) (R11) (R16) (R17)
      msg_err <= next_msg_err;
      bcst_rx <= next_bcst_rx; // (R10) (R15) (R20)
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // shutdown codes only store and reply; transmitter enables are not touched here (R13)
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      pend_status <= 1'b0;
      ram_valid <= 1'b0;
      ram <= '0;
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (mine && tx_ok && tx_int) begin
            resp_valid <= 1'b1; // (R1)
            resp <= '{send_status: 1'b1, send_data: 1'b1, data: next_bit_word};
          end else if (go_rd) begin
            state <= ST_RD;
            busy <= 1'b1;
            ram_valid <= 1'b1;
            ram <= '{we: 1'b0, addr: ram_addr_sel, wdata: 16'h0000};
          end else if (go_wr) begin
            state <= ST_WR;
            busy <= 1'b1;
            pend_status <= !msg.bcst; // (R9) (R10) (R12) (R15)
            ram_valid <= 1'b1;
            ram <= '{we: 1'b1, addr: ram_addr_sel, wdata: msg.data};
          end
        end
        ST_RD: begin
          if (ram_ack) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            ram_valid <= 1'b0;
            resp_valid <= 1'b1; // (R19) (R21)
            resp <= '{send_status: 1'b1, send_data: 1'b1, data: ram_rdata};
          end
        end
        ST_WR: begin
          if (ram_ack) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            ram_valid <= 1'b0;
            resp_valid <= pend_status;
            resp <= '{send_status: 1'b1, send_data: 1'b0, data: 16'h0000};
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
          ram_valid <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- design/mch_pkg.sv ----
// package: constants, register map and carriers for the upper mode code handler
package mch_pkg;

  // ****************************************
  // mode codes
  // ****************************************
  localparam logic [4:0] MC_TX_BIT = 5'h13;
  localparam logic [4:0] MC_FIRST = 5'h13;

  // ****************************************
  // enhanced mode code storage map
  // ****************************************
  localparam logic [7:0] ENH_PAGE = 8'h01;
  localparam logic [3:0] ENH_RX_NIB = 4'h1;
  localparam logic [3:0] ENH_TX_NIB = 4'h2;
  localparam logic [3:0] ENH_BC_NIB = 4'h3;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_CFG3 = 6'h00;
  localparam logic [5:0] OFS_CFG4 = 6'h04;
  localparam logic [5:0] OFS_PTR_RX0 = 6'h08;
  localparam logic [5:0] OFS_PTR_RX31 = 6'h0C;
  localparam logic [5:0] OFS_PTR_TX0 = 6'h10;
  localparam logic [5:0] OFS_PTR_TX31 = 6'h14;
  localparam logic [5:0] OFS_BITW = 6'h18;
  localparam logic [5:0] OFS_STAT = 6'h1C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CFG3_ENH_MODE = 15;
  localparam int CFG3_ENH_MC = 0;
  localparam int CFG4_EXT_BIT = 15;
  localparam int BIT_HI_WC = 6;
  localparam int BIT_LO_WC = 5;
  localparam int BIT_CMD_ERR = 4;
  localparam int ST_MSG_ERR = 1;
  localparam int ST_BCST_RX = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ok;
    logic bcst;
    logic tx;
    logic sa31;
    logic [4:0] code;
    logic [1:0] ndata;
    logic [15:0] data;
  } mch_msg_s;

  typedef struct packed {
    logic send_status;
    logic send_data;
    logic [15:0] data;
  } mch_resp_s;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mch_ram_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD = 2'b01,
    ST_WR = 2'b10
  } mch_state_e;

endpackage

// ---- test/mch_mode_upper_asserts.sv ----
// checker: port assertions for the upper mode code handler
`timescale 1ns/1ps
`default_nettype none
module mch_mode_upper_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire logic msg_valid,
  input wire mch_pkg::mch_msg_s msg,
  input wire logic busy,
  input wire logic resp_valid,
  input wire mch_pkg::mch_resp_s resp,
  input wire logic ram_valid,
  input wire mch_pkg::mch_ram_s ram,
  input wire logic msg_err,
  input wire logic bcst_rx,
  input wire logic [15:0] bit_word
);
  import mch_pkg::*;
  // ****************
  // message rules
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // lower codes belong to the other handler
  wire logic tk = msg_valid && !busy && msg.ok && msg.code >= MC_FIRST;
  chk_bit_reply: assert property (tk && msg.tx && !msg.bcst && msg.code == MC_TX_BIT
    && msg.ndata == 2'd0 |=> (resp_valid && resp.send_data && resp.data == bit_word)
    || (ram_valid && !ram.we)) else $error("bit reply");
  chk_hi_count: assert property (tk && msg.tx && !msg.bcst && msg.ndata != 2'd0
    |=> msg_err && bit_word[BIT_HI_WC] && !resp_valid) else $error("high count");
  chk_lo_count: assert property (tk && !msg.tx && msg.ndata == 2'd0
    |=> msg_err && bit_word[BIT_LO_WC] && !resp_valid) else $error("low count");
  chk_many_words: assert property (tk && !msg.tx && msg.ndata[1]
    |=> msg_err && bit_word[BIT_HI_WC] && !ram_valid) else $error("many words");
  chk_bcst_tx: assert property (tk && msg.tx && msg.bcst
    |=> msg_err && bcst_rx && bit_word[BIT_CMD_ERR]) else $error("bcst tx");
  chk_bcst_silent: assert property (tk && msg.bcst |=> !resp_valid [*8])
    else $error("bcst reply");
  chk_rx_store: assert property (tk && !msg.tx && !msg.bcst && msg.ndata == 2'd1
    |=> ram_valid && ram.we && ram.wdata == $past(msg.data)) else $error("rx store");
  chk_tx_fetch: assert property (tk && msg.tx && !msg.bcst && msg.code != MC_TX_BIT
    && msg.ndata == 2'd0 |=> ram_valid && !ram.we) else $error("tx fetch");
  chk_busy_ram: assert property (busy == ram_valid)
    else $error("busy and ram cycle disagree");
endmodule
bind mch_mode_upper mch_mode_upper_asserts u_chk (.clk(clk), .rstn(rstn), .msg_valid(msg_valid),
  .msg(msg), .busy(busy), .resp_valid(resp_valid), .resp(resp), .ram_valid(ram_valid),
  .ram(ram), .msg_err(msg_err), .bcst_rx(bcst_rx), .bit_word(bit_word));
`default_nettype wire

// ---- test/mch_mode_upper_tb.sv ----
// testbench: register and message scenarios for the upper mode code handler
`timescale 1ns/1ps
`default_nettype none
module mch_mode_upper_tb;
  import mch_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rv;
  logic avs_waitrequest, busy, resp_valid, ram_valid, ram_ack, msg_err, bcst_rx;
  logic msg_valid = 1'b0;
  mch_msg_s msg = '0;
  mch_resp_s resp;
  mch_ram_s ram;
  logic [15:0] ram_rdata, bit_word;
  logic [16:0] last_acc;
  logic [7:0] n_acc;
  int n_fail = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  mch_mode_upper u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .msg_valid(msg_valid), .msg(msg), .busy(busy), .resp_valid(resp_valid), .resp(resp),
    .ram_valid(ram_valid), .ram(ram), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
    .msg_err(msg_err), .bcst_rx(bcst_rx), .bit_word(bit_word));
  mch_ram_model u_ram (.clk(clk), .rstn(rstn), .ram_valid(ram_valid), .ram(ram),
    .ram_ack(ram_ack), .ram_rdata(ram_rdata), .last_acc(last_acc), .n_acc(n_acc));
  // ****************
  // tasks
  // ****************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 10 && avs_waitrequest !== 1'b0; i++) @(posedge clk);
    if (i == 10) begin
      n_fail++;
      complete_run();
    end
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // e: msg_err, bcst_rx, high, low, command error; cleared afterwards
  task automatic flg(input logic [4:0] e);
    av(1'b0, OFS_STAT, 32'h0);
    chk(rv, {30'h0, e[4:3]});
    av(1'b0, OFS_BITW, 32'h0);
    chk(rv, {25'h0, e[2:0], 4'h0});
    av(1'b1, OFS_BITW, 32'hFFFF);
    av(1'b1, OFS_STAT, 32'h3);
  endtask
  // f: ok, bcst, tx, sa31; k: 0 no ram, 1 read, 2 write; rs: 0 none, 2 status, 3 with data
  task automatic send(input logic [3:0] f, input logic [4:0] c, input int n, input int k,
    input logic [15:0] a, input int rs);
    logic [7:0] na;
    mch_resp_s rr;
    na = n_acc;
    rr = '0;
    @(posedge clk);
    msg_valid <= 1'b1;
    msg <= {f, c, n[1:0], 11'h2A6, c};
    @(posedge clk);
    msg_valid <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (resp_valid === 1'b1) rr = resp;
    end
    chk({rr.send_status, rr.send_data}, rs);
    if (rs == 3) chk(rr.data, k == 1 ? a ^ 16'hA5A5 : a);
    chk(n_acc - na, k != 0);
    if (k != 0) chk(last_acc, {k == 2, a});
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    int c;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    av(1'b1, 6'h3C, 32'hFFFF);
    for (c = 0; c < 48; c += 4) begin
      av(1'b0, c[5:0], 32'h0);
      chk(rv, 32'h0);
    end
    send(4'hA, 5'h13, 0, 0, 16'h0000, 3);
    send(4'h2, 5'h13, 0, 0, 16'h0000, 0);
    flg(5'b00000);
    send(4'hA, 5'h13, 1, 0, 16'h0000, 0);
    send(4'hA, 5'h13, 0, 0, 16'h0040, 3);
    flg(5'b10100);
    send(4'h8, 5'h13, 0, 0, 16'h0000, 0);
    flg(5'b10010);
    send(4'hE, 5'h13, 0, 0, 16'h0000, 0);
    flg(5'b11001);
    $display("test internal done");
    av(1'b1, OFS_CFG3, 32'h8000);
    av(1'b1, OFS_CFG4, 32'h8000);
    av(1'b1, OFS_PTR_TX0, 32'h0200);
    av(1'b1, OFS_PTR_TX31, 32'h0300);
    av(1'b1, OFS_PTR_RX0, 32'h0210);
    av(1'b1, OFS_PTR_RX31, 32'h0310);
    send(4'hA, 5'h13, 0, 1, 16'h0200, 3);
    send(4'hB, 5'h13, 0, 1, 16'h0300, 3);
    send(4'h8, 5'h14, 1, 2, 16'h0210, 2);
    send(4'h9, 5'h15, 1, 2, 16'h0310, 2);
    send(4'hA, 5'h16, 0, 1, 16'h0200, 3);
    av(1'b1, OFS_CFG4, 32'h0);
    send(4'hA, 5'h13, 0, 0, 16'h0000, 3);
    $display("test pointer done");
    av(1'b1, OFS_CFG3, 32'h8001);
    av(1'b1, OFS_CFG4, 32'h8000);
    send(4'hA, 5'h13, 0, 1, 16'h0123, 3);
    send(4'h8, 5'h13, 1, 2, 16'h0113, 2);
    send(4'hC, 5'h13, 1, 2, 16'h0133, 0);
    flg(5'b01000);
    send(4'h8, 5'h14, 1, 2, 16'h0114, 2);
    flg(5'b00000);
    send(4'h8, 5'h15, 1, 2, 16'h0115, 2);
    send(4'hA, 5'h14, 0, 1, 16'h0124, 3);
    send(4'hA, 5'h15, 0, 1, 16'h0125, 3);
    send(4'hA, 5'h14, 1, 0, 16'h0000, 0);
    flg(5'b10100);
    send(4'hE, 5'h15, 0, 0, 16'h0000, 0);
    flg(5'b11001);
    send(4'h8, 5'h14, 0, 0, 16'h0000, 0);
    flg(5'b10010);
    send(4'h8, 5'h15, 2, 0, 16'h0000, 0);
    flg(5'b10100);
    for (c = 22; c < 32; c++) begin
      send(4'h8, c[4:0], 1, 2, {12'h011, c[3:0]}, 2);
      send(4'hA, c[4:0], 0, 1, {12'h012, c[3:0]}, 3);
      send(4'hC, c[4:0], 1, 2, {12'h013, c[3:0]}, 0);
    end
    flg(5'b01000);
    // lane 0 only: upper byte of the pointer must survive
    avs_byteenable <= 4'h1;
    av(1'b1, OFS_PTR_TX0, 32'h1234);
    avs_byteenable <= 4'hF;
    av(1'b0, OFS_PTR_TX0, 32'h0);
    chk(rv, 32'h0234);
    $display("test enhanced done");
    complete_run();
  end
endmodule
`default_nettype wire

// ---- test/mch_ram_model.sv ----
// partner: shared ram giving alternate fast and slow acks
`timescale 1ns/1ps
`default_nettype none
module mch_ram_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ram port and access log
  input wire logic ram_valid,
  input wire mch_pkg::mch_ram_s ram,
  output logic ram_ack,
  output logic [15:0] ram_rdata,
  output logic [16:0] last_acc,
  output logic [7:0] n_acc
);
  import mch_pkg::*;
  logic [1:0] cnt;
  // rdata toggles off ack so stale data never matches
  always_ff @(posedge clk) begin
    ram_ack <= 1'b0;
    ram_rdata <= ~ram_rdata;
    if (!rstn) begin
      cnt <= 2'h0;
      n_acc <= 8'h00;
      ram_rdata <= 16'h0000;
    end else if (ram_valid && !ram_ack) begin
      cnt <= cnt + 2'h1;
      if (cnt == {2{n_acc[0]}}) begin
        cnt <= 2'h0;
        ram_ack <= 1'b1;
        ram_rdata <= ram.addr ^ 16'hA5A5;
        last_acc <= {ram.we, ram.addr};
        n_acc <= n_acc + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
